/* File: common/sapc_pkg.sv */
// constants, kinds and helper functions of the address/parity codec
package sapc_pkg;
    localparam logic [23:0] SAPC_GEN = 24'hfff409; // low 24 coefficients, x^24 implied
    localparam logic [23:0] SAPC_GEN_REV = 24'h205fff; // reciprocal, top term dropped
    localparam logic [6:0] SAPC_INFO_SHORT = 7'h20; // 32 info bits
    localparam logic [6:0] SAPC_INFO_LONG = 7'h58; // 88 info bits
    localparam logic [6:0] SAPC_PAR_LEN = 7'h18; // 24 parity bits
    localparam logic [23:0] SAPC_REM_RST = 24'h000000;
    localparam logic [4:0] SAPC_THR_RST = 5'h00;
    // overlay kinds
    localparam logic [1:0] SAPC_K_UPLINK = 2'h0;
    localparam logic [1:0] SAPC_K_REPLY = 2'h1;
    localparam logic [1:0] SAPC_K_DF11 = 2'h2;
    localparam logic [1:0] SAPC_K_BARE = 2'h3;
    // end-of-message outcomes
    localparam logic [1:0] SAPC_ST_OK = 2'h0;
    localparam logic [1:0] SAPC_ST_FIXED = 2'h1;
    localparam logic [1:0] SAPC_ST_BAD = 2'h2;

    // upper 24 bits of the 48-bit carry-less product address * generator
    function automatic logic [23:0] sapc_addr_mul_hi(input logic [23:0] a);
        logic [47:0] p;
        p = 48'h0;
        for (int i = 0; i < 24; i++)
        begin
            if (a[i])
                p = p ^ ({23'h0, 1'b1, SAPC_GEN} << i);
        end
        return p[47:24];
    endfunction

    // overlay pattern per kind; shared by encoder and checker
    function automatic logic [23:0] sapc_pattern(input logic [1:0] k, input logic [23:0] a,
                                                 input logic [2:0] cl, input logic [3:0] ic);
        case (k)
            SAPC_K_UPLINK: return sapc_addr_mul_hi(a);
            SAPC_K_REPLY: return a;
            SAPC_K_DF11: return {17'h0, cl, ic};
            default: return 24'h000000;
        endcase
    endfunction

    function automatic logic [23:0] sapc_rev24(input logic [23:0] v);
        logic [23:0] r;
        r = 24'h0;
        for (int i = 0; i < 24; i++)
            r[i] = v[23 - i];
        return r;
    endfunction
endpackage

/* File: common/sapc_div_if.sv */
// control and remainder bundle between codec and its serial divider
`timescale 1ns/10ps
interface sapc_div_if;
    logic clr; // zero the remainder
    logic step; // advance one bit
    logic feed; // 1: divide with din, 0: plain shift out
    logic din; // next message bit
    logic [23:0] rem; // running remainder
    modport ctl (output clr, output step, output feed, output din, input rem);
    modport div (input clr, input step, input feed, input din, output rem);
endinterface

/* File: hdl/sapc_div.sv */
// serial 24-stage premultiplied divider by the generator polynomial
`timescale 1ns/10ps
module sapc_div
    import sapc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic arst_n_i,
    sapc_div_if.div d
);
    logic [23:0] rem_q; // remainder stages
    logic [23:0] rem_d;
    logic fb; // feedback term

    // din enters at the top, which is the same as appending 24 zeros
    assign fb = d.feed & (rem_q[23] ^ d.din);
    assign rem_d = d.clr ? SAPC_REM_RST
                 : !d.step ? rem_q
                 : ({rem_q[22:0], 1'b0} ^ (fb ? SAPC_GEN : 24'h000000));
    assign d.rem = rem_q;

    // remainder register
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            rem_q <= SAPC_REM_RST;
        else
            rem_q <= rem_d;
    end

    AST_DIV_CLR: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        d.clr |=> rem_q == 24'h000000) else $error("divider not cleared");
    AST_DIV_SHIFT: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        d.step && !d.feed && !d.clr |=> rem_q == {$past(rem_q[22:0]), 1'b0})
        else $error("parity shift-out altered remainder");
endmodule

/* File: hdl/sapc_codec.sv */
// address/parity encoder, checker and burst corrector for 56/112-bit messages
`timescale 1ns/10ps
module sapc_codec
    import sapc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // transmit request
    input wire logic tx_start_i,
    input wire logic tx_long_i,
    input wire logic [87:0] tx_info_i,
    input wire logic [1:0] tx_kind_i,
    input wire logic [23:0] tx_addr_i,
    input wire logic [2:0] tx_cl_i,
    input wire logic [3:0] tx_ic_i,
    // transmit bit stream
    output logic tx_busy_o,
    output logic tx_valid_o,
    output logic tx_bit_o,
    output logic tx_last_o,
    // receive set-up
    input wire logic rx_start_i,
    input wire logic rx_long_i,
    input wire logic [1:0] rx_kind_i,
    input wire logic [23:0] rx_addr_i,
    input wire logic [2:0] rx_cl_i,
    input wire logic [3:0] rx_ic_i,
    input wire logic [4:0] rx_thr_i,
    // receive bit stream
    input wire logic rx_valid_i,
    input wire logic rx_bit_i,
    input wire logic rx_lowconf_i,
    // result towards the message buffer
    output logic rx_busy_o,
    output logic rx_done_o,
    output logic [1:0] rx_stat_o,
    output logic [111:0] rx_msg_o,
    output logic [23:0] rx_syn_o
);
    typedef enum logic [2:0] {E_IDLE = 3'b001, E_INFO = 3'b010, E_PAR = 3'b100} sapc_enc_t;
    typedef enum logic [3:0] {D_IDLE = 4'b0001, D_RX = 4'b0010, D_CHK = 4'b0100,
                              D_FIX = 4'b1000} sapc_dec_t;

    sapc_div_if enc_if ();
    sapc_div_if dec_if ();

    // encoder state
    sapc_enc_t e_q; // encoder phase
    logic [87:0] info_q; // info bits, next one at the top
    logic [23:0] epat_q; // overlay pattern, next bit at the top
    logic [6:0] ecnt_q; // bits left in the phase
    logic tx_busy_q;
    logic tx_valid_q;
    logic tx_bit_q;
    logic tx_last_q;
    // decoder state
    sapc_dec_t d_q; // decoder phase
    logic [111:0] msg_q; // received bits, last one at bit 0
    logic [111:0] conf_q; // low-confidence marks, same layout
    logic [111:0] cw_q; // confidence copy that slides right
    logic [23:0] der_q; // received field xor computed parity
    logic [23:0] exp_q; // expected pattern
    logic [23:0] rs_q; // bit-reversed working syndrome
    logic [23:0] syn_q; // initial syndrome
    logic [6:0] ilen_q; // info length
    logic [6:0] rcnt_q; // bits received
    logic [6:0] k_q; // current slide offset
    logic [6:0] lim_q; // last legal offset
    logic [4:0] win_q; // low marks in the last 24 bits
    logic [4:0] thr_q; // refusal threshold
    logic over_q; // some window exceeded threshold
    logic up_q; // uplink check: no correction
    logic rx_busy_q;
    logic rx_done_q;
    logic [1:0] rx_stat_q;
    logic [111:0] rx_msg_q;

    // decode and helper nets
    logic e_go;
    logic e_info_end;
    logic e_par_end;
    logic d_go;
    logic d_take;
    logic d_in_info;
    logic d_last;
    logic [4:0] win_d;
    logic [23:0] syn_now;
    logic [23:0] s_cur;
    logic fix_hit;
    logic fix_end;
    logic [23:0] rs_next;
    logic [111:0] fix_mask;

    sapc_div u_enc_div (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .d(enc_if.div)
    );
    sapc_div u_dec_div (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .d(dec_if.div)
    );

    // encoder control; new requests ignored while busy
    assign e_go = (e_q == E_IDLE) & tx_start_i;
    assign e_info_end = (e_q == E_INFO) & (ecnt_q == 7'h01);
    assign e_par_end = (e_q == E_PAR) & (ecnt_q == 7'h01);
    assign enc_if.clr = e_go;
    assign enc_if.step = (e_q == E_INFO) | (e_q == E_PAR);
    assign enc_if.feed = (e_q == E_INFO);
    assign enc_if.din = info_q[87];

    // encoder phase sequencing
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            e_q <= E_IDLE;
            ecnt_q <= 7'h00;
        end
        else
        begin
            case (e_q)
                E_IDLE:
                begin
                    e_q <= e_go ? E_INFO : E_IDLE;
                    ecnt_q <= tx_long_i ? SAPC_INFO_LONG : SAPC_INFO_SHORT;
                end
                E_INFO:
                begin
                    e_q <= e_info_end ? E_PAR : E_INFO;
                    ecnt_q <= e_info_end ? SAPC_PAR_LEN : ecnt_q - 7'h01;
                end
                E_PAR:
                begin
                    e_q <= e_par_end ? E_IDLE : E_PAR;
                    ecnt_q <= ecnt_q - 7'h01;
                end
                default:
                begin
                    e_q <= E_IDLE;
                    ecnt_q <= 7'h00;
                end
            endcase
        end
    end

    // encoder data: info bits left aligned, msb sent first
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            info_q <= 88'h0;
            epat_q <= 24'h000000;
        end
        else if (e_go)
        begin
            info_q <= tx_long_i ? tx_info_i : {tx_info_i[31:0], 56'h0};
            epat_q <= sapc_pattern(tx_kind_i, tx_addr_i, tx_cl_i, tx_ic_i);
        end
        else if (e_q == E_INFO)
            info_q <= {info_q[86:0], 1'b0};
        else if (e_q == E_PAR)
            epat_q <= {epat_q[22:0], 1'b0};
    end

    // serial output register: info unchanged, then parity xor overlay
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            tx_busy_q <= 1'b0;
            tx_valid_q <= 1'b0;
            tx_bit_q <= 1'b0;
            tx_last_q <= 1'b0;
        end
        else
        begin
            tx_busy_q <= e_go | ((e_q != E_IDLE) & !e_par_end);
            tx_valid_q <= enc_if.step;
            tx_bit_q <= (e_q == E_INFO) ? info_q[87]
                      : (enc_if.rem[23] ^ epat_q[23]) & (e_q == E_PAR);
            tx_last_q <= e_par_end;
        end
    end

    // decoder decode
    assign d_go = (d_q == D_IDLE) & rx_start_i;
    assign d_take = (d_q == D_RX) & rx_valid_i;
    assign d_in_info = rcnt_q < ilen_q;
    assign d_last = d_take & (rcnt_q == ilen_q + SAPC_PAR_LEN - 7'h01);
    assign dec_if.clr = d_go;
    assign dec_if.step = d_take;
    assign dec_if.feed = d_in_info;
    assign dec_if.din = rx_bit_i;
    // sliding count of low marks; the bit leaving the window is conf_q[23]
    assign win_d = win_q + {4'h0, rx_lowconf_i} - {4'h0, conf_q[23]};
    assign syn_now = der_q ^ exp_q;
    assign s_cur = sapc_rev24(rs_q);
    assign fix_hit = ~|(s_cur & ~cw_q[23:0]);
    assign fix_end = k_q == lim_q;
    assign rs_next = {rs_q[22:0], 1'b0} ^ (rs_q[23] ? SAPC_GEN_REV : 24'h000000);
    // variable shifter only used once per message on a hit
    assign fix_mask = {88'h0, s_cur} << k_q;

    // receive capture: message, confidence, window count, derived field
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            msg_q <= 112'h0;
            conf_q <= 112'h0;
            der_q <= 24'h000000;
            rcnt_q <= 7'h00;
            win_q <= 5'h00;
            over_q <= 1'b0;
        end
        else if (d_go)
        begin
            msg_q <= 112'h0;
            conf_q <= 112'h0;
            der_q <= 24'h000000;
            rcnt_q <= 7'h00;
            win_q <= 5'h00;
            over_q <= 1'b0;
        end
        else if (d_take)
        begin
            msg_q <= {msg_q[110:0], rx_bit_i};
            conf_q <= {conf_q[110:0], rx_lowconf_i};
            rcnt_q <= rcnt_q + 7'h01;
            win_q <= win_d;
            over_q <= over_q | (win_d > thr_q);
            if (!d_in_info)
                der_q <= {der_q[22:0], rx_bit_i ^ dec_if.rem[23]};
        end
    end

    // checker and corrector sequencing
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            d_q <= D_IDLE;
            ilen_q <= SAPC_INFO_SHORT;
            lim_q <= 7'h00;
            exp_q <= 24'h000000;
            thr_q <= SAPC_THR_RST;
            up_q <= 1'b0;
            syn_q <= 24'h000000;
            rs_q <= 24'h000000;
            cw_q <= 112'h0;
            k_q <= 7'h00;
            rx_done_q <= 1'b0;
            rx_stat_q <= SAPC_ST_OK;
            rx_msg_q <= 112'h0;
        end
        else
        begin
            rx_done_q <= 1'b0;
            case (d_q)
                D_IDLE:
                begin
                    if (d_go)
                    begin
                        d_q <= D_RX;
                        ilen_q <= rx_long_i ? SAPC_INFO_LONG : SAPC_INFO_SHORT;
                        lim_q <= rx_long_i ? SAPC_INFO_LONG : SAPC_INFO_SHORT;
                        exp_q <= sapc_pattern(rx_kind_i, rx_addr_i, rx_cl_i, rx_ic_i);
                        thr_q <= rx_thr_i;
                        up_q <= rx_kind_i == SAPC_K_UPLINK;
                    end
                end
                D_RX:
                    d_q <= d_last ? D_CHK : D_RX;
                D_CHK:
                begin
                    syn_q <= syn_now;
                    rs_q <= sapc_rev24(syn_now);
                    cw_q <= conf_q;
                    k_q <= 7'h00;
                    if (syn_now == 24'h000000)
                    begin
                        d_q <= D_IDLE;
                        rx_done_q <= 1'b1;
                        rx_stat_q <= SAPC_ST_OK;
                        rx_msg_q <= msg_q;
                    end
                    else if (up_q | over_q)
                    begin
                        d_q <= D_IDLE;
                        rx_done_q <= 1'b1;
                        rx_stat_q <= SAPC_ST_BAD;
                        rx_msg_q <= msg_q;
                    end
                    else
                        d_q <= D_FIX;
                end
                D_FIX:
                begin
                    if (fix_hit)
                    begin
                        d_q <= D_IDLE;
                        rx_done_q <= 1'b1;
                        rx_stat_q <= SAPC_ST_FIXED;
                        rx_msg_q <= msg_q ^ fix_mask;
                    end
                    else if (fix_end)
                    begin
                        d_q <= D_IDLE;
                        rx_done_q <= 1'b1;
                        rx_stat_q <= SAPC_ST_BAD;
                        rx_msg_q <= msg_q;
                    end
                    else
                    begin
                        rs_q <= rs_next;
                        cw_q <= {1'b0, cw_q[111:1]};
                        k_q <= k_q + 7'h01;
                    end
                end
                default:
                    d_q <= D_IDLE;
            endcase
        end
    end

    // busy flag registered so the output stays a flop
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            rx_busy_q <= 1'b0;
        else
            rx_busy_q <= d_go | ((d_q != D_IDLE) & !rx_done_q & !((d_q == D_FIX) & (fix_hit | fix_end))
                         & !((d_q == D_CHK) & ((syn_now == 24'h000000) | up_q | over_q)));
    end

    assign tx_busy_o = tx_busy_q;
    assign tx_valid_o = tx_valid_q;
    assign tx_bit_o = tx_bit_q;
    assign tx_last_o = tx_last_q;
    assign rx_busy_o = rx_busy_q;
    assign rx_done_o = rx_done_q;
    assign rx_stat_o = rx_stat_q;
    assign rx_msg_o = rx_msg_q;
    assign rx_syn_o = syn_q;

    sequence s_par_run;
        (e_q == E_PAR)[*8];
    endsequence
    sequence s_par_out;
        tx_valid_o[*8];
    endsequence
    AST_ENC_FIELD: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        e_info_end |=> s_par_run ##1 s_par_out) else $error("parity field not right after info");
    AST_HIGH_CONF: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        rx_done_o && rx_stat_o == SAPC_ST_FIXED |-> ((rx_msg_o ^ msg_q) & ~conf_q) == 112'h0)
        else $error("high-confidence bit changed");
    AST_TRAP_STOP: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        d_q == D_FIX && fix_hit |=> d_q == D_IDLE && rx_stat_o == SAPC_ST_FIXED)
        else $error("correction continued after trap");
    AST_OK_ZERO: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        rx_done_o && rx_stat_o == SAPC_ST_OK |-> syn_q == 24'h000000 && rx_msg_o == msg_q)
        else $error("ok reported with nonzero syndrome");
    AST_UP_REJ: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        d_q == D_CHK && up_q && syn_now != 24'h000000 |=> rx_done_o && rx_stat_o == SAPC_ST_BAD)
        else $error("uplink with wrong remainder not rejected");
    AST_THR: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        rx_done_o && over_q |-> rx_stat_o != SAPC_ST_FIXED) else $error("correction despite threshold");
endmodule

/* File: verif/sapc_stream_model.sv */
// demodulator bit-stream model feeding the receive side of the codec
`timescale 1ns/10ps
module sapc_stream_model
(
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic send_i, // load one frame
    input wire logic slow_i, // stall a cycle after each bit
    input wire logic [6:0] n_i, // frame length in bits
    input wire logic [111:0] msg_i, // frame, first bit at n_i-1
    input wire logic [111:0] low_i, // low-confidence marks per bit
    output logic valid_o,
    output logic bit_o,
    output logic low_o,
    output logic busy_o
);
    logic [111:0] msg_q; // next bit at the top
    logic [111:0] low_q; // marks, aligned with msg_q
    logic [6:0] left_q; // bits still to send
    logic gap_q; // stall phase of slow mode
    assign busy_o = (left_q != 7'h00) || valid_o;
    // one bit per cycle or every other cycle; lines toggle when idle
    always @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            msg_q <= '0;
            low_q <= '0;
            left_q <= 7'h00;
            gap_q <= 1'b0;
            valid_o <= 1'b0;
            bit_o <= 1'b0;
            low_o <= 1'b0;
        end
        else if (send_i)
        begin
            msg_q <= msg_i << (7'h70 - n_i);
            low_q <= low_i << (7'h70 - n_i);
            left_q <= n_i;
            valid_o <= 1'b0;
        end
        else if ((left_q != 7'h00) && !gap_q)
        begin
            valid_o <= 1'b1;
            bit_o <= msg_q[111];
            low_o <= low_q[111];
            msg_q <= msg_q << 1;
            low_q <= low_q << 1;
            left_q <= left_q - 7'h01;
            gap_q <= slow_i;
        end
        else
        begin
            // stale data must never look valid to the codec
            valid_o <= 1'b0;
            bit_o <= ~bit_o;
            low_o <= ~low_o;
            gap_q <= 1'b0;
        end
    end
endmodule

/* File: verif/sapc_codec_test.sv */
// self-checking bench of the address/parity codec
`timescale 1ns/10ps
module sapc_codec_test;
    import sapc_pkg::*;
    localparam logic [23:0] T_GEN = 24'hfff409; // exponents 0,3,10,12..23
    logic mclk_i, arst_n_i;
    logic tx_start, tx_long, tx_busy, tx_valid, tx_bit, tx_last;
    logic [87:0] tx_info;
    logic [1:0] tx_kind, rx_kind, rx_stat;
    logic [23:0] tx_addr, rx_addr, rx_syn;
    logic [2:0] tx_cl, rx_cl;
    logic [3:0] tx_ic, rx_ic;
    logic rx_start, rx_long, rx_valid, rx_bit, rx_low, rx_busy, rx_done;
    logic [4:0] rx_thr;
    logic [111:0] rx_msg, m_msg, m_low;
    logic m_send, m_slow, m_busy;
    logic [6:0] m_n;
    int n_fail, check_count, cyc;
    sapc_codec i_sapc_codec (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .tx_start_i(tx_start),
        .tx_long_i(tx_long), .tx_info_i(tx_info), .tx_kind_i(tx_kind), .tx_addr_i(tx_addr),
        .tx_cl_i(tx_cl), .tx_ic_i(tx_ic), .tx_busy_o(tx_busy), .tx_valid_o(tx_valid),
        .tx_bit_o(tx_bit), .tx_last_o(tx_last), .rx_start_i(rx_start), .rx_long_i(rx_long),
        .rx_kind_i(rx_kind), .rx_addr_i(rx_addr), .rx_cl_i(rx_cl), .rx_ic_i(rx_ic),
        .rx_thr_i(rx_thr), .rx_valid_i(rx_valid), .rx_bit_i(rx_bit), .rx_lowconf_i(rx_low),
        .rx_busy_o(rx_busy), .rx_done_o(rx_done), .rx_stat_o(rx_stat), .rx_msg_o(rx_msg),
        .rx_syn_o(rx_syn));
    sapc_stream_model i_sapc_stream_model (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
        .send_i(m_send), .slow_i(m_slow), .n_i(m_n), .msg_i(m_msg), .low_i(m_low),
        .valid_o(rx_valid), .bit_o(rx_bit), .low_o(rx_low), .busy_o(m_busy));
    // 200 MHz clock
    initial
    begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end
    // hang guard, far above the few thousand cycles needed
    always @(posedge mclk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input string what, input logic [111:0] seen, input logic [111:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // remainder by g; pre set means info premultiplied by x^24
    function automatic logic [23:0] ref_rem(input logic [111:0] v, input int n, input logic pre);
        logic [23:0] r;
        logic fb;
        r = 24'h0;
        for (int i = n - 1; i >= 0; i--)
        begin
            fb = r[23] ^ (pre & v[i]);
            r = {r[22:0], ~pre & v[i]} ^ (fb ? T_GEN : 24'h0);
        end
        return r;
    endfunction
    // overlay pattern; cl and ic taken from the address bits
    function automatic logic [23:0] ref_pat(input logic [1:0] k, input logic [23:0] a);
        logic [47:0] p;
        p = 48'h0;
        for (int i = 0; i < 24; i++)
            if (a[i]) p = p ^ ({24'h1, T_GEN} << i);
        case (k)
            SAPC_K_UPLINK: return p[47:24];
            SAPC_K_REPLY: return a;
            SAPC_K_DF11: return {17'h0, a[2:0], a[7:4]};
            default: return 24'h0;
        endcase
    endfunction
    function automatic logic [111:0] ref_msg(input logic lng, input logic [1:0] k,
                                             input logic [87:0] info, input logic [23:0] a);
        logic [111:0] v;
        v = lng ? {24'h0, info} : {80'h0, info[31:0]};
        return (v << 24) | {88'h0, ref_rem(v, lng ? 88 : 32, 1'b1) ^ ref_pat(k, a)};
    endfunction
    task automatic tx_frame(input logic lng, input logic [1:0] k, input logic [87:0] info,
                            input logic [23:0] a);
        logic [111:0] cap;
        int cnt;
        int last_at;
        cap = '0;
        cnt = 0;
        last_at = 0;
        tx_long = lng;
        tx_kind = k;
        tx_info = info;
        tx_addr = a;
        tx_cl = a[2:0];
        tx_ic = a[7:4];
        tx_start = 1'b1;
        @(posedge mclk_i);
        // start just taken: busy already up, first bit one edge later
        #1 tx_start = 1'b0;
        check("tx_valid early", tx_valid, 1'b0);
        check("tx busy early", tx_busy, 1'b1);
        @(posedge mclk_i);
        #1 check("tx_valid start", tx_valid, 1'b1);
        // capture until the stream drops, bounded
        while (tx_valid === 1'b1 && cnt < 120)
        begin
            cap = {cap[110:0], tx_bit};
            cnt++;
            if (tx_last === 1'b1) last_at = cnt;
            @(posedge mclk_i);
            #1;
        end
        check("tx length", cnt, lng ? 112 : 56);
        check("tx last", last_at, cnt);
        check("tx frame", cap, ref_msg(lng, k, info, a));
        check("tx busy", tx_busy, 1'b0);
    endtask
    // arm the receiver, stream one frame, wait for the result
    task automatic rx_run(input logic lng, input logic [1:0] k, input logic [23:0] a, input logic [4:0] thr,
                          input logic [111:0] msg, input logic [111:0] low, input logic slow);
        int w;
        rx_long = lng;
        rx_kind = k;
        rx_addr = a;
        rx_cl = a[2:0];
        rx_ic = a[7:4];
        rx_thr = thr;
        m_n = lng ? 7'h70 : 7'h38;
        m_msg = msg;
        m_low = low;
        m_slow = slow;
        rx_start = 1'b1;
        @(posedge mclk_i);
        #1 rx_start = 1'b0;
        check("rx busy start", rx_busy, 1'b1);
        m_send = 1'b1;
        @(posedge mclk_i);
        #1 m_send = 1'b0;
        w = 0;
        while (rx_done !== 1'b1 && w < 400)
        begin
            @(posedge mclk_i);
            #1 w++;
        end
        check("rx done", rx_done, 1'b1);
        check("rx busy end", rx_busy, 1'b0);
        check("model idle", m_busy, 1'b0);
        @(posedge mclk_i);
        #1 check("rx done pulse", rx_done, 1'b0);
    endtask
    task automatic tx_all_kinds();
        for (int i = 0; i < 8; i++)
            tx_frame(i[0], i[2:1], {11{8'ha3 + 8'(i)}}, 24'h3c5a96 + 24'(i));
    endtask
    task automatic rx_clean_all();
        logic [111:0] m;
        for (int i = 0; i < 8; i++)
        begin
            m = ref_msg(i[0], i[2:1], {11{8'h6d - 8'(i)}}, 24'h9e1377);
            rx_run(i[0], i[2:1], 24'h9e1377, 5'h18, m, '0, i[1]);
            check("rx clean stat", rx_stat, SAPC_ST_OK);
            check("rx clean msg", rx_msg, m);
            check("rx clean syn", rx_syn, 24'h0);
        end
    endtask
    task automatic rx_wrong_addr();
        for (int k = 0; k < 2; k++)
        begin
            rx_run(1'b1, k[1:0], 24'h123457, 5'h18, ref_msg(1'b1, k[1:0], 88'h5, 24'h123456), '0, 1'b0);
            check("rx wrong addr", rx_stat, SAPC_ST_BAD);
        end
    endtask
    task automatic rx_burst_fix();
        int offs[4] = '{0, 17, 88, 32};
        logic [111:0] m;
        logic [111:0] e;
        for (int i = 0; i < 4; i++)
        begin
            m = ref_msg(i < 3, SAPC_K_REPLY, 88'hc0ffee_1234_5678, 24'h4b2d1e);
            e = {88'h0, 24'hc00a05} << offs[i];
            rx_run(i < 3, SAPC_K_REPLY, 24'h4b2d1e, 5'h18, m ^ e, e, 1'b1);
            check("rx fix stat", rx_stat, SAPC_ST_FIXED);
            check("rx fix msg", rx_msg, m);
            check("rx fix syn", rx_syn, ref_rem(e, i < 3 ? 112 : 56, 1'b0));
        end
    endtask
    task automatic rx_high_conf();
        logic [111:0] m;
        logic [111:0] e;
        m = ref_msg(1'b1, SAPC_K_DF11, 88'h77, 24'h0000a5);
        e = {88'h0, 24'hc00a05} << 40;
        rx_run(1'b1, SAPC_K_DF11, 24'h0000a5, 5'h18, m ^ e ^ (112'h1 << 70), e, 1'b0);
        check("rx high conf", rx_stat, SAPC_ST_BAD);
    endtask
    task automatic rx_threshold();
        logic [111:0] m;
        logic [111:0] e;
        m = ref_msg(1'b1, SAPC_K_REPLY, 88'h31, 24'h5a5a5a);
        e = {88'h0, 24'hc00a05} << 5;
        // six low bits: limit six corrects, limit five refuses
        for (int j = 0; j < 2; j++)
        begin
            rx_run(1'b1, SAPC_K_REPLY, 24'h5a5a5a, 5'h06 - 5'(j), m ^ e, e, 1'b0);
            check("rx threshold", rx_stat, j ? SAPC_ST_BAD : SAPC_ST_FIXED);
        end
    endtask
    // main sequence: reset for six cycles, then the scenarios
    initial
    begin
        {arst_n_i, tx_start, tx_long, tx_info, tx_kind, tx_addr, tx_cl, tx_ic} = '0;
        {rx_start, rx_long, rx_kind, rx_addr, rx_cl, rx_ic, rx_thr} = '0;
        {m_send, m_slow, m_n, m_msg, m_low} = '0;
        repeat (6) @(posedge mclk_i);
        #1 arst_n_i = 1'b1;
        tx_all_kinds();
        rx_clean_all();
        rx_wrong_addr();
        rx_burst_fix();
        rx_high_conf();
        rx_threshold();
        tally_and_finish();
    end
endmodule
